/* core/adc_host_port.sv */
`timescale 1ns/1ps
module adc_host_port #(
  parameter int WIDTH = adc_port_pkg::WORD_W
) (
  input wire logic clk, // System clock, 100 MHz
  input wire logic sys_rst, // Async reset, high
  input wire logic chip_select_low_n, // First chip select pin, low active
  input wire logic chip_select_high, // Second chip select pin, high active
  input wire logic rd_n, // Read pin, low active
  input wire logic wr_n, // Write pin, or read/write line
  input wire logic [WIDTH-1:0] data_in, // Data bus, pin level
  output logic [WIDTH-1:0] data_out, // Data bus, driven word
  output logic data_oe, // Data bus drive enable
  input wire logic conv_valid, // Pulse, raw conversion done
  input wire logic [WIDTH-1:0] conv_data, // Raw conversion, two's complement
  output logic [adc_port_pkg::CTRL0_W-1:0] ctrl0_fields, // First control word fields
  output logic device_in_reset, // Soft reset held
  output logic sync_gen_reset, // Pulse, sync generator reset
  output logic offset_zero_inputs, // Inputs zeroed for calibration
  output logic format_binary, // Output format in use
  output logic result_taken // Pulse, result read by host
);
  import adc_port_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] ctrl0;
    logic [WIDTH-1:0] ctrl1;
    logic in_reset;
    logic sync_pulse;
    logic cal_pulse;
    logic soft_pulse;
    logic wr_strobe;
    logic rd_strobe;
    logic [WIDTH-1:0] wr_word;
    logic [WIDTH-1:0] data_out;
    readback_phase_e rb_phase;
    logic taken;
  } port_s;

  port_s st;
  port_s next_st;

  logic [3:0] pins_s;
  logic [WIDTH-1:0] data_s;
  logic cs_low_n_s;
  logic cs_high_s;
  logic rd_n_s;
  logic wr_n_s;
  logic cs_act;
  logic rd_act;
  logic wr_act;
  logic [WIDTH-1:0] result_word;

  if (WIDTH != WORD_W)
  begin : g_bad_width
    $error("adc_host_port serves only the documented word width");
  end

  // Selector must sit in the two top bits
  if (SEL_HI != WIDTH - 1 || SEL_LO != WIDTH - 2)
  begin : g_bad_selector
    $error("adc_host_port selector must use the two top bits");
  end

  // First word fields fill all bits below the selector
  if (CTRL0_W != SEL_LO)
  begin : g_bad_ctrl0_width
    $error("adc_host_port first word field width must match the selector");
  end

  // Pin filter is built for three stages
  if (SYNC_STAGES != 3)
  begin : g_bad_stages
    $error("adc_host_port pin filter serves only three stages");
  end

  // Reset words must carry their own selectors
  if (CTRL0_RESET[SEL_HI:SEL_LO] != SEL_CTRL0)
  begin : g_bad_ctrl0_reset
    $error("adc_host_port first word reset value has a wrong selector");
  end

  if (CTRL1_RESET[SEL_HI:SEL_LO] != SEL_CTRL1)
  begin : g_bad_ctrl1_reset
    $error("adc_host_port second word reset value has a wrong selector");
  end

  // Reset word must not request any action
  if (CTRL1_RESET[BIT_DEV_RESET] || CTRL1_RESET[BIT_SYNC_RESET] || CTRL1_RESET[BIT_OFFSET_CAL])
  begin : g_bad_reset_action
    $error("adc_host_port second word reset value holds an action bit");
  end

  // Action bits must lie below the selector
  if (BIT_DEV_RESET >= SEL_LO || BIT_SYNC_RESET >= SEL_LO || BIT_OFFSET_CAL >= SEL_LO)
  begin : g_bad_action_bits
    $error("adc_host_port action bit overlaps the selector");
  end

  if (BIT_STROBE_MODE >= SEL_LO || BIT_FORMAT >= SEL_LO || BIT_READBACK >= SEL_LO)
  begin : g_bad_mode_bits
    $error("adc_host_port mode bit overlaps the selector");
  end

  // After reset the host must reach results with separate strobes
  if (CTRL1_RESET[BIT_STROBE_MODE] != 1'b0 || CTRL1_RESET[BIT_READBACK] != 1'b0)
  begin : g_bad_reset_mode
    $error("adc_host_port second word reset value selects a wrong mode");
  end

  pin_sync #(
    .WIDTH(4),
    .INIT(PIN_IDLE)
  ) u_ctrl_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din({chip_select_low_n, chip_select_high, rd_n, wr_n}),
    .dout(pins_s)
  );

  // Same latency as the strobes keeps data aligned
  pin_sync #(
    .WIDTH(WIDTH),
    .INIT('0)
  ) u_data_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(data_in),
    .dout(data_s)
  );

  result_path #(
    .WIDTH(WIDTH)
  ) u_result (
    .clk(clk),
    .sys_rst(sys_rst),
    .soft_reset(st.soft_pulse),
    .cal_start(st.cal_pulse),
    .format_binary(st.ctrl1[BIT_FORMAT]),
    .conv_valid(conv_valid),
    .conv_data(conv_data),
    .zero_inputs(offset_zero_inputs),
    .result(result_word),
    .result_valid()
  );

  assign cs_low_n_s = pins_s[3];
  assign cs_high_s = pins_s[2];
  assign rd_n_s = pins_s[1];
  assign wr_n_s = pins_s[0];

  always_comb
  begin
    cs_act = !cs_low_n_s && cs_high_s;
    if (st.ctrl1[BIT_STROBE_MODE])
    begin
      // Read pin ignored, write pin gives direction
      rd_act = cs_act && wr_n_s;
      wr_act = cs_act && !wr_n_s;
    end
    else
    begin
      rd_act = cs_act && !rd_n_s && wr_n_s;
      wr_act = cs_act && !wr_n_s && rd_n_s;
    end
  end

  always_comb
  begin
    next_st = st;
    next_st.sync_pulse = 1'b0;
    next_st.cal_pulse = 1'b0;
    next_st.soft_pulse = 1'b0;
    next_st.taken = 1'b0;
    // Strobe follows the first inactive input
    next_st.wr_strobe = wr_act;
    next_st.rd_strobe = rd_act;
    if (wr_act)
    begin
      next_st.wr_word = data_s;
    end
    // Commit word as the write strobe ends
    if (st.wr_strobe && !wr_act)
    begin
      if (is_sel(st.wr_word, SEL_CTRL1))
      begin
        if (st.wr_word[BIT_DEV_RESET])
        begin
          next_st.ctrl0 = CTRL0_RESET;
          next_st.ctrl1 = CTRL1_RESET;
          next_st.in_reset = 1'b1;
          next_st.soft_pulse = 1'b1;
          next_st.rb_phase = RB_FIRST;
        end
        else
        begin
          // A zero in the reset bit releases
          next_st.in_reset = 1'b0;
          next_st.ctrl1 = st.wr_word;
          next_st.sync_pulse = st.wr_word[BIT_SYNC_RESET];
          next_st.cal_pulse = st.wr_word[BIT_OFFSET_CAL];
          next_st.rb_phase = RB_FIRST;
        end
      end
      else if (is_sel(st.wr_word, SEL_CTRL0) && !st.in_reset)
      begin
        next_st.ctrl0 = st.wr_word;
      end
    end
    // Output word loaded as read strobe starts
    if (rd_act && !st.rd_strobe)
    begin
      if (st.ctrl1[BIT_READBACK])
      begin
        // First read word zero, then word one
        case (st.rb_phase)
          RB_FIRST:
          begin
            next_st.data_out = st.ctrl0;
            next_st.rb_phase = RB_SECOND;
          end
          RB_SECOND:
          begin
            next_st.data_out = st.ctrl1;
            next_st.rb_phase = RB_HOLD;
          end
          RB_HOLD:
          begin
            next_st.data_out = st.ctrl1;
          end
          default:
          begin
            next_st.rb_phase = RB_FIRST;
          end
        endcase
      end
      else
      begin
        next_st.data_out = result_word;
        next_st.taken = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= '{
        ctrl0: CTRL0_RESET,
        ctrl1: CTRL1_RESET,
        in_reset: 1'b0,
        sync_pulse: 1'b0,
        cal_pulse: 1'b0,
        soft_pulse: 1'b0,
        wr_strobe: 1'b0,
        rd_strobe: 1'b0,
        wr_word: '0,
        data_out: '0,
        rb_phase: RB_FIRST,
        taken: 1'b0
      };
    end
    else
    begin
      st <= next_st;
    end
  end

  // Drivers enabled only during read strobe
  assign data_oe = st.rd_strobe;
  assign data_out = st.data_out;
  assign ctrl0_fields = st.ctrl0[CTRL0_W-1:0];
  assign device_in_reset = st.in_reset;
  assign sync_gen_reset = st.sync_pulse;
  assign format_binary = st.ctrl1[BIT_FORMAT];
  assign result_taken = st.taken;

endmodule

/* core/adc_port_pkg.sv */
package adc_port_pkg;

  localparam int WORD_W = 12;
  localparam int CTRL0_W = 10;
  localparam int SYNC_STAGES = 3;

  // Selector field at the top of every control word
  localparam int SEL_HI = 11;
  localparam int SEL_LO = 10;
  localparam logic [1:0] SEL_CTRL0 = 2'h0;
  localparam logic [1:0] SEL_CTRL1 = 2'h1;

  // Second control word field positions
  localparam int BIT_DEV_RESET = 0;
  localparam int BIT_SYNC_RESET = 1;
  localparam int BIT_STROBE_MODE = 6;
  localparam int BIT_FORMAT = 7;
  localparam int BIT_OFFSET_CAL = 8;
  localparam int BIT_READBACK = 9;

  // Values after reset, selector included
  localparam logic [WORD_W-1:0] CTRL0_RESET = 12'h020;
  localparam logic [WORD_W-1:0] CTRL1_RESET = 12'h430;

  // Pin levels while idle
  localparam logic [3:0] PIN_IDLE = 4'hb;

  typedef enum logic [1:0] {RB_FIRST, RB_SECOND, RB_HOLD} readback_phase_e;
  typedef enum logic {CAL_IDLE, CAL_WAIT} cal_state_e;

  function automatic logic is_sel(input logic [WORD_W-1:0] word, input logic [1:0] sel);
    is_sel = (word[SEL_HI:SEL_LO] == sel);
  endfunction

endpackage

/* core/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Async reset, high
  input wire logic [WIDTH-1:0] din, // Pin levels
  output logic [WIDTH-1:0] dout // Filtered levels
);
  import adc_port_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
  } sync_s;

  sync_s st;
  sync_s next_st;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("pin_sync width must be at least one");
  end

  always_comb
  begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // A change counts once stages two and three agree
    for (int i = 0; i < WIDTH; i++)
    begin
      if (st.s2[i] == st.s3[i])
      begin
        next_st.stable[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= {INIT, INIT, INIT, INIT};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign dout = st.stable;

endmodule

/* core/result_path.sv */
`timescale 1ns/1ps
module result_path #(
  parameter int WIDTH = adc_port_pkg::WORD_W
) (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Async reset, high
  input wire logic soft_reset, // Clears stored offset
  input wire logic cal_start, // Pulse, start offset calibration
  input wire logic format_binary, // 1 straight binary, 0 two's complement
  input wire logic conv_valid, // Pulse, raw result present
  input wire logic [WIDTH-1:0] conv_data, // Raw result, two's complement
  output logic zero_inputs, // Inputs held at zero for calibration
  output logic [WIDTH-1:0] result, // Corrected, formatted result
  output logic result_valid // Pulse, new result stored
);
  import adc_port_pkg::*;

  typedef struct packed {
    cal_state_e cal;
    logic [WIDTH-1:0] offset;
    logic [WIDTH-1:0] result;
    logic result_valid;
    logic zero_inputs;
  } path_s;

  path_s st;
  path_s next_st;
  logic signed [WIDTH:0] diff;
  logic [WIDTH-1:0] corrected;

  if (WIDTH < 2)
  begin : g_bad_width
    $error("result_path width must be at least two");
  end

  always_comb
  begin
    next_st = st;
    next_st.result_valid = 1'b0;
    diff = $signed({conv_data[WIDTH-1], conv_data}) - $signed({st.offset[WIDTH-1], st.offset});
    // Saturate instead of wrapping
    if (diff[WIDTH] != diff[WIDTH-1])
    begin
      corrected = {diff[WIDTH], {(WIDTH-1){~diff[WIDTH]}}};
    end
    else
    begin
      corrected = diff[WIDTH-1:0];
    end
    case (st.cal)
      CAL_IDLE:
      begin
        if (cal_start)
        begin
          next_st.cal = CAL_WAIT;
        end
        else if (conv_valid)
        begin
          next_st.result = corrected;
          if (format_binary)
          begin
            next_st.result[WIDTH-1] = ~corrected[WIDTH-1];
          end
          next_st.result_valid = 1'b1;
        end
      end
      CAL_WAIT:
      begin
        if (conv_valid)
        begin
          next_st.offset = conv_data;
          next_st.cal = CAL_IDLE;
        end
      end
      default:
      begin
        next_st.cal = CAL_IDLE;
      end
    endcase
    if (soft_reset)
    begin
      next_st.cal = CAL_IDLE;
      next_st.offset = '0;
    end
    // Registered so the pin comes straight from a flop
    next_st.zero_inputs = (next_st.cal == CAL_WAIT);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= '{cal: CAL_IDLE, offset: '0, result: '0, result_valid: 1'b0, zero_inputs: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign zero_inputs = st.zero_inputs;
  assign result = st.result;
  assign result_valid = st.result_valid;

endmodule

/* verification/adc_host_port_asserts.sv */
`timescale 1ns/1ps
module adc_host_port_asserts
  import adc_port_pkg::*;
#(
  parameter int WIDTH = WORD_W
) (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic chip_select_low_n, // Select low
  input wire logic wr_n, // Write pin
  input wire logic [WIDTH-1:0] data_in, // Bus level
  input wire logic [WIDTH-1:0] data_out, // Bus word
  input wire logic data_oe, // Bus enable
  input wire logic conv_valid, // Raw strobe
  input wire logic [CTRL0_W-1:0] ctrl0_fields, // Word zero
  input wire logic device_in_reset, // Soft reset
  input wire logic sync_gen_reset, // Sync pulse
  input wire logic offset_zero_inputs, // Calibrating
  input wire logic format_binary, // Format
  input wire logic result_taken // Read pulse
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_oe_after_select: assert property ($rose(data_oe) |-> !$past(chip_select_low_n, 3))
    else $error("drive without select");
  a_oe_drop: assert property (chip_select_low_n [*6] |-> !data_oe)
    else $error("drive after select off");
  a_oe_no_write: assert property (!wr_n [*6] |-> !data_oe)
    else $error("drive during write");
  a_data_hold: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
    else $error("bus word moved");
  a_taken_oe: assert property (result_taken |-> ##[0:1] data_oe)
    else $error("taken without drive");
  a_sync_cause: assert property (sync_gen_reset |-> $past(data_in[BIT_SYNC_RESET], 3))
    else $error("sync pulse without bit");
  a_sync_pulse: assert property (sync_gen_reset |=> !sync_gen_reset)
    else $error("sync pulse too long");
  a_reset_ctrl0: assert property (device_in_reset |-> ctrl0_fields == CTRL0_RESET[9:0])
    else $error("word zero not default");
  a_reset_format: assert property ($rose(device_in_reset) |-> !format_binary)
    else $error("format not default");
  a_format_cause: assert property ($changed(format_binary) |-> !$past(wr_n, 8))
    else $error("format moved without write");
  a_cal_end: assert property (offset_zero_inputs && conv_valid |=> !offset_zero_inputs)
    else $error("calibration not ended");
endmodule

bind adc_host_port adc_host_port_asserts #(.WIDTH(WIDTH)) chk_u (.clk(clk), .sys_rst(sys_rst),
  .chip_select_low_n(chip_select_low_n), .wr_n(wr_n), .data_in(data_in),
  .data_out(data_out), .data_oe(data_oe), .conv_valid(conv_valid),
  .ctrl0_fields(ctrl0_fields), .device_in_reset(device_in_reset),
  .sync_gen_reset(sync_gen_reset), .offset_zero_inputs(offset_zero_inputs),
  .format_binary(format_binary), .result_taken(result_taken));

/* verification/adc_host_port_tb.sv */
`timescale 1ns/1ps
module adc_host_port_tb;
  import adc_port_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic chip_select_low_n, chip_select_high, rd_n, wr_n, data_oe;
  logic conv_valid = 1'b0;
  logic device_in_reset, sync_gen_reset, offset_zero_inputs, format_binary, result_taken;
  logic [11:0] data_in, data_out, q;
  logic [11:0] conv_data = 12'h000;
  logic [9:0] ctrl0_fields;
  int bad_count = 0;
  int cmp_count = 0;
  int sync_cnt = 0;
  int taken_cnt = 0;
  always #5 clk = ~clk;
  // Pulses counted mid-cycle, where they are settled
  always @(negedge clk)
  begin
    if (sync_gen_reset === 1'b1)
      sync_cnt++;
    if (result_taken === 1'b1)
      taken_cnt++;
  end
  adc_host_port #(.WIDTH(12)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .chip_select_low_n(chip_select_low_n), .chip_select_high(chip_select_high),
    .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .conv_valid(conv_valid), .conv_data(conv_data), .ctrl0_fields(ctrl0_fields),
    .device_in_reset(device_in_reset), .sync_gen_reset(sync_gen_reset),
    .offset_zero_inputs(offset_zero_inputs), .format_binary(format_binary),
    .result_taken(result_taken));
  host_model host_u (.clk(clk), .data_out(data_out), .data_oe(data_oe),
    .chip_select_low_n(chip_select_low_n), .chip_select_high(chip_select_high),
    .rd_n(rd_n), .wr_n(wr_n), .bus(data_in));
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrw(input logic [11:0] w);
    host_u.access(1'b1, 1'b0, w, q);
  endtask
  task automatic rdw();
    host_u.access(1'b0, 1'b1, 12'h000, q);
  endtask
  task automatic conv(input logic [11:0] v);
    @(negedge clk);
    conv_data = v;
    conv_valid = 1'b1;
    @(negedge clk);
    conv_valid = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic t_reset();
    chk("ctrl0", 12'h020, {2'h0, ctrl0_fields});
    chk("format", 12'h000, {11'h0, format_binary});
    chk("oe", 12'h000, {11'h0, data_oe});
    $display("test reset done");
  endtask
  task automatic t_readback();
    wrw(12'h0ab);
    chk("ctrl0", 12'h0ab, {2'h0, ctrl0_fields});
    wrw(12'h600);
    rdw();
    chk("rb_first", 12'h0ab, q);
    rdw();
    chk("rb_second", 12'h600, q);
    rdw();
    chk("rb_third", 12'h600, q);
    chk("taken", 12'h000, 12'(taken_cnt));
    wrw(12'h400);
    $display("test readback done");
  endtask
  task automatic t_format();
    taken_cnt = 0;
    wrw(12'h480);
    chk("format", 12'h001, {11'h0, format_binary});
    conv(12'h005);
    rdw();
    chk("res_bin", 12'h805, q);
    chk("taken", 12'h001, 12'(taken_cnt));
    wrw(12'h400);
    conv(12'h005);
    rdw();
    chk("res_twos", 12'h005, q);
    $display("test format done");
  endtask
  task automatic t_offset();
    wrw(12'h500);
    chk("zero_in", 12'h001, {11'h0, offset_zero_inputs});
    conv(12'h003);
    chk("zero_in", 12'h000, {11'h0, offset_zero_inputs});
    conv(12'h010);
    rdw();
    chk("res_off", 12'h00d, q);
    conv(12'h800);
    rdw();
    chk("res_sat", 12'h800, q);
    $display("test offset done");
  endtask
  task automatic t_sync();
    sync_cnt = 0;
    wrw(12'h402);
    chk("sync", 12'h001, 12'(sync_cnt));
    wrw(12'h400);
    chk("sync", 12'h001, 12'(sync_cnt));
    $display("test sync done");
  endtask
  task automatic t_soft();
    wrw(12'h0ff);
    wrw(12'h401);
    chk("in_reset", 12'h001, {11'h0, device_in_reset});
    chk("ctrl0", 12'h020, {2'h0, ctrl0_fields});
    wrw(12'h011);
    chk("ctrl0", 12'h020, {2'h0, ctrl0_fields});
    chk("in_reset", 12'h001, {11'h0, device_in_reset});
    wrw(12'h400);
    chk("in_reset", 12'h000, {11'h0, device_in_reset});
    conv(12'h010);
    rdw();
    chk("res_clr", 12'h010, q);
    $display("test soft reset done");
  endtask
  task automatic t_strobe();
    host_u.access(1'b0, 1'b0, 12'h0cc, q);
    chk("ctrl0", 12'h020, {2'h0, ctrl0_fields});
    wrw(12'h440);
    host_u.access(1'b0, 1'b0, 12'h033, q);
    chk("ctrl0", 12'h033, {2'h0, ctrl0_fields});
    conv(12'h021);
    host_u.access(1'b1, 1'b1, 12'h000, q);
    chk("res_dir", 12'h021, q);
    host_u.access(1'b1, 1'b0, 12'h400, q);
    conv(12'h022);
    host_u.access(1'b1, 1'b1, 12'h000, q);
    chk("no_read", 12'hfff, q);
    $display("test strobe done");
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #200000;
    bad_count++;
    print_verdict();
  end
  initial
  begin
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    t_reset();
    t_readback();
    t_format();
    t_offset();
    t_sync();
    t_soft();
    t_strobe();
    print_verdict();
  end
endmodule

/* verification/host_model.sv */
`timescale 1ns/1ps
module host_model (
  input wire logic clk, // Clock
  input wire logic [11:0] data_out, // Device word
  input wire logic data_oe, // Device enable
  output logic chip_select_low_n, // Select low
  output logic chip_select_high, // Select high
  output logic rd_n, // Read pin
  output logic wr_n, // Write pin
  output wire logic [11:0] bus // Bus level
);
  logic drv = 1'b0;
  logic [11:0] hw = 12'h000;
  // Released bus shows inverse of last word
  assign bus = drv ? hw : (data_oe ? data_out : ~hw);
  initial
  begin
    chip_select_low_n = 1'b1;
    chip_select_high = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
  end
  task automatic access(input logic rdv, input logic wrv, input logic [11:0] w,
    output logic [11:0] q);
    @(negedge clk);
    chip_select_low_n = 1'b0;
    chip_select_high = 1'b1;
    rd_n = rdv;
    wr_n = wrv;
    hw = w;
    drv = !wrv;
    repeat (8) @(negedge clk);
    q = bus;
    chip_select_low_n = 1'b1;
    chip_select_high = 1'b0;
    @(negedge clk);
    rd_n = 1'b1;
    wr_n = 1'b1;
    repeat (6) @(negedge clk);
    drv = 1'b0;
    repeat (4) @(negedge clk);
  endtask
endmodule
